// ===== src/tcm_defs.svh
// Offsets, field positions, reset values and codes of the channel 1/2 mode block.
// Included by the filter, the mode block and the testbench; holds definitions only.
`ifndef TCM_DEFS_SVH
`define TCM_DEFS_SVH

// Register byte offsets on the AHB-Lite slave
`define TCM_MODE_OFS 8'h00
`define TCM_CMP_OFS 8'h04
`define TCM_STAT_OFS 8'h08

// Reset values
`define TCM_MODE_RST 16'h0000
`define TCM_CMP_RST 16'h0000

// Field positions in the mode register
`define TCM_SEL1_LSB 0
`define TCM_PSC1_LSB 2
`define TCM_FLT1_LSB 4
`define TCM_SEL2_LSB 8
`define TCM_FEN2_BIT 10
`define TCM_PEN2_BIT 11
`define TCM_OMOD2_LSB 12
`define TCM_CEN2_BIT 15
`define TCM_PSC2_LSB 10
`define TCM_FLT2_LSB 12

// Direction / source selection codes
`define TCM_SEL_OUTPUT 2'h0
`define TCM_SEL_OWN_PIN 2'h1
`define TCM_SEL_NEIGH_PIN 2'h2
`define TCM_SEL_TRIGGER 2'h3

// Output mode codes
`define TCM_OM_FREEZE 3'h0
`define TCM_OM_SET_MATCH 3'h1
`define TCM_OM_CLR_MATCH 3'h2
`define TCM_OM_TOG_MATCH 3'h3
`define TCM_OM_FORCE_LOW 3'h4
`define TCM_OM_FORCE_HIGH 3'h5
`define TCM_OM_PWM_BELOW 3'h6
`define TCM_OM_PWM_ABOVE 3'h7

// Filter code that bypasses the filter
`define TCM_FLT_BYPASS 4'h0

`endif

// ===== src/tcm_pkg.sv
// Types shared by the channel 1/2 mode block and its input filter.
// Constants live in tcm_defs.svh; this package holds the state records only.
`default_nettype none
package tcm_pkg;

    typedef struct packed {
        logic out;
        logic [2:0] agreeCnt;
        logic [4:0] divCnt;
    } tcm_filt_state_t;

    typedef struct packed {
        logic dataPhase;
        logic dataWrite;
        logic [7:0] dataAddr;
        logic [15:0] mode;
        logic [15:0] cmpWritten;
        logic [15:0] cmpActive;
        logic outRef;
        logic [1:0] capEvent;
        logic [1:0] prevIn;
        logic [1:0][2:0] psCnt;
        logic [31:0] rdata;
        logic readyOut;
        logic fastEn;
    } tcm_state_t;

endpackage
`default_nettype wire

// ===== src/tcm_input_filter.sv
// Digital input filter for one timer input pin.
// Assumes the pin is synchronous to ref_clk and rstN is already synchronised.
`timescale 1ns/1ns
`default_nettype none
`include "tcm_defs.svh"

module tcm_input_filter (
    input wire logic ref_clk, // timer clock
    input wire logic rstN, // synchronised reset, active low
    input wire logic rawIn, // pin level
    input wire logic [3:0] filterCode, // 0 bypasses
    output logic filtered // filtered level
);
    import tcm_pkg::*;

    tcm_filt_state_t s_q;
    tcm_filt_state_t s_d;
    logic [4:0] divMask;
    logic [2:0] nMinus1;
    logic tick;

    always_comb begin
        // Divider as a mask on a free counter, sample count less one
        unique case (filterCode)
            4'h0: {divMask, nMinus1} = {5'h00, 3'h0};
            4'h1: {divMask, nMinus1} = {5'h00, 3'h1};
            4'h2: {divMask, nMinus1} = {5'h00, 3'h3};
            4'h3: {divMask, nMinus1} = {5'h00, 3'h7};
            4'h4: {divMask, nMinus1} = {5'h01, 3'h5};
            4'h5: {divMask, nMinus1} = {5'h01, 3'h7};
            4'h6: {divMask, nMinus1} = {5'h03, 3'h5};
            4'h7: {divMask, nMinus1} = {5'h03, 3'h7};
            4'h8: {divMask, nMinus1} = {5'h07, 3'h5};
            4'h9: {divMask, nMinus1} = {5'h07, 3'h7};
            4'ha: {divMask, nMinus1} = {5'h0f, 3'h4};
            4'hb: {divMask, nMinus1} = {5'h0f, 3'h5};
            4'hc: {divMask, nMinus1} = {5'h0f, 3'h7};
            4'hd: {divMask, nMinus1} = {5'h1f, 3'h4};
            4'he: {divMask, nMinus1} = {5'h1f, 3'h5};
            4'hf: {divMask, nMinus1} = {5'h1f, 3'h7};
        endcase
        tick = (s_q.divCnt & divMask) == 5'h00;
        s_d = s_q;
        s_d.divCnt = s_q.divCnt + 5'h01;
        if (filterCode == `TCM_FLT_BYPASS) begin
            s_d.out = rawIn;
            s_d.agreeCnt = 3'h0;
        end else if (tick) begin
            // A sample equal to the current output restarts the run toward the new level
            if (rawIn == s_q.out) begin
                s_d.agreeCnt = 3'h0;
            end else if (s_q.agreeCnt == nMinus1) begin
                s_d.out = rawIn;
                s_d.agreeCnt = 3'h0;
            end else begin
                s_d.agreeCnt = s_q.agreeCnt + 3'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign filtered = s_q.out;

    ////////////////////////////////////////////////////////////////////////////
    chk_bypass_follow: assert property (@(posedge ref_clk) disable iff (!rstN)
        filterCode == `TCM_FLT_BYPASS |=> filtered == $past(rawIn))
        else $error("bypassed filter did not follow the pin");

    chk_filter_wait: assert property (@(posedge ref_clk) disable iff (!rstN)
        (filterCode != `TCM_FLT_BYPASS && s_q.agreeCnt != nMinus1) |=> $stable(filtered))
        else $error("filter passed a level before the sample count was reached");

endmodule
`default_nettype wire

// ===== src/tcm_ch12_mode.sv
// Mode control for capture/compare channels 1 and 2 with an AHB-Lite register slave.
// Assumes counter, update event and channel enables come from the rest of the timer on ref_clk.
//
// Behaviour
// - Channel-2 selection 00 makes it an output and 11 takes its input from the internal trigger source.
// - Output layout puts fast response at bit 10, preload at 11, output mode at 14:12, clear enable at 15.
// - Output mode codes give freeze, set, clear, toggle on match, force low, force high and the two PWM modes.
// - With clear enable set the reference is held low while the external trigger filtered input is high.
// - Without preload a compare write acts at once; with preload it waits for the next update event.
// - Channel-1 selection 00 is output, 01 pin one, 10 pin two, 11 the internal trigger source.
// - The channel-1 prescaler captures on every 1st, 2nd, 4th or 8th valid edge.
// - Filter code 0000 samples the input directly at the timer clock.
// - The filter passes a new level only after the selected count of agreeing samples at the divided rate.
// - Channel 2 has its prescaler at 11:10 and filter at 15:12 with channel 1's behaviour.
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "tcm_defs.svh"

module tcm_ch12_mode (
    input wire logic ref_clk, // timer clock, 250 MHz
    input wire logic nrst, // asynchronous reset, active low
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, word only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response, always OKAY
    output logic [31:0] hrdata, // AHB read data
    input wire logic inputPinOne, // timer input pin one
    input wire logic inputPinTwo, // timer input pin two
    input wire logic internalTriggerSource, // internal trigger input
    input wire logic externalTriggerFiltered, // external clear input
    input wire logic ch1EnableBit, // channel 1 enabled
    input wire logic ch2EnableBit, // channel 2 enabled
    input wire logic [15:0] counterValue, // timer count
    input wire logic updateEvent, // update event pulse
    output logic ch1CaptureEvent, // capture pulse, channel 1
    output logic ch2CaptureEvent, // capture pulse, channel 2
    output logic ch2OutputReference, // channel 2 output reference
    output logic ch2FastResponseEn // fast response bit, output layout
);
    import tcm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    logic [1:0] rstSync_q;
    logic rstN;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstN = rstSync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Input filters, one per pin; filter fields count only in input layout
    logic [1:0] pinLevel;
    logic [1:0] filtLevel;
    logic [1:0][3:0] filtCode;
    tcm_state_t s_q;
    tcm_state_t s_d;

    assign pinLevel = {inputPinTwo, inputPinOne};
    assign filtCode[0] = (s_q.mode[`TCM_SEL1_LSB+:2] != `TCM_SEL_OUTPUT) ?
        s_q.mode[`TCM_FLT1_LSB+:4] : `TCM_FLT_BYPASS;
    assign filtCode[1] = (s_q.mode[`TCM_SEL2_LSB+:2] != `TCM_SEL_OUTPUT) ?
        s_q.mode[`TCM_FLT2_LSB+:4] : `TCM_FLT_BYPASS;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_filt
            tcm_input_filter u_filt (
                .ref_clk(ref_clk),
                .rstN(rstN),
                .rawIn(pinLevel[gi]),
                .filterCode(filtCode[gi]),
                .filtered(filtLevel[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    logic addrPhase;
    logic wrMode;
    logic wrCmp;
    logic cmpMatch;
    logic [15:0] newMode;
    logic [1:0] sel [2];
    logic [1:0] srcIn;
    logic [2:0] factorMinus1 [2];
    logic [1:0] chActive;
    logic [1:0] chEnable;

    assign chEnable = {ch2EnableBit, ch1EnableBit};
    assign sel[0] = s_q.mode[`TCM_SEL1_LSB+:2];
    assign sel[1] = s_q.mode[`TCM_SEL2_LSB+:2];

    always_comb begin
        s_d = s_q;
        addrPhase = hsel && hready && htrans[1] && (hsize == 3'h2);
        wrMode = s_q.dataPhase && s_q.dataWrite && (s_q.dataAddr == `TCM_MODE_OFS);
        wrCmp = s_q.dataPhase && s_q.dataWrite && (s_q.dataAddr == `TCM_CMP_OFS);
        cmpMatch = counterValue == s_q.cmpActive;
        newMode = hwdata[15:0];
        // A selection locked by its enable keeps its value; the other bits still land
        if (ch1EnableBit) begin
            newMode[`TCM_SEL1_LSB+:2] = s_q.mode[`TCM_SEL1_LSB+:2];
        end
        if (ch2EnableBit) begin
            newMode[`TCM_SEL2_LSB+:2] = s_q.mode[`TCM_SEL2_LSB+:2];
        end
        if (wrMode) begin
            s_d.mode = newMode;
        end
        // Bit 10 is a prescaler bit in input layout, so fast response only shows in output layout
        s_d.fastEn = (s_d.mode[`TCM_SEL2_LSB+:2] == `TCM_SEL_OUTPUT) && s_d.mode[`TCM_FEN2_BIT];

        // Compare value: newest write wins over a same-cycle update transfer
        if (wrCmp) begin
            s_d.cmpWritten = hwdata[15:0];
        end
        if (!s_q.mode[`TCM_PEN2_BIT] && wrCmp) begin
            s_d.cmpActive = hwdata[15:0];
        end else if (s_q.mode[`TCM_PEN2_BIT] && updateEvent) begin
            s_d.cmpActive = s_d.cmpWritten;
        end

        // Channel 2 output reference, driven only in output layout
        if (sel[1] == `TCM_SEL_OUTPUT) begin
            unique case (s_q.mode[`TCM_OMOD2_LSB+:3])
                `TCM_OM_FREEZE: s_d.outRef = s_q.outRef;
                `TCM_OM_SET_MATCH: s_d.outRef = cmpMatch ? 1'b1 : s_q.outRef;
                `TCM_OM_CLR_MATCH: s_d.outRef = cmpMatch ? 1'b0 : s_q.outRef;
                `TCM_OM_TOG_MATCH: s_d.outRef = cmpMatch ? !s_q.outRef : s_q.outRef;
                `TCM_OM_FORCE_LOW: s_d.outRef = 1'b0;
                `TCM_OM_FORCE_HIGH: s_d.outRef = 1'b1;
                `TCM_OM_PWM_BELOW: s_d.outRef = counterValue < s_q.cmpActive;
                `TCM_OM_PWM_ABOVE: s_d.outRef = counterValue > s_q.cmpActive;
            endcase
            if (s_q.mode[`TCM_CEN2_BIT] && externalTriggerFiltered) begin
                s_d.outRef = 1'b0;
            end
        end else begin
            s_d.outRef = 1'b0;
        end

        // Capture path per channel: source, rising edge, prescaler
        for (int i = 0; i < 2; i++) begin
            unique case (sel[i])
                `TCM_SEL_OUTPUT: srcIn[i] = 1'b0;
                `TCM_SEL_OWN_PIN: srcIn[i] = filtLevel[i];
                `TCM_SEL_NEIGH_PIN: srcIn[i] = filtLevel[1-i];
                `TCM_SEL_TRIGGER: srcIn[i] = internalTriggerSource;
            endcase
            unique case (i == 0 ? s_q.mode[`TCM_PSC1_LSB+:2] : s_q.mode[`TCM_PSC2_LSB+:2])
                2'h0: factorMinus1[i] = 3'h0;
                2'h1: factorMinus1[i] = 3'h1;
                2'h2: factorMinus1[i] = 3'h3;
                2'h3: factorMinus1[i] = 3'h7;
            endcase
            chActive[i] = chEnable[i] && (sel[i] != `TCM_SEL_OUTPUT);
            s_d.prevIn[i] = srcIn[i];
            s_d.capEvent[i] = 1'b0;
            if (!chActive[i]) begin
                s_d.psCnt[i] = 3'h0;
            end else if (srcIn[i] && !s_q.prevIn[i]) begin
                if (s_q.psCnt[i] == factorMinus1[i]) begin
                    s_d.capEvent[i] = 1'b1;
                    s_d.psCnt[i] = 3'h0;
                end else begin
                    s_d.psCnt[i] = s_q.psCnt[i] + 3'h1;
                end
            end
        end

        // Bus: zero wait states; read data built from next state so a read right after a write sees it
        s_d.readyOut = 1'b1;
        s_d.dataPhase = addrPhase && (haddr[31:8] == 24'h00_0000);
        s_d.dataWrite = hwrite;
        s_d.dataAddr = haddr[7:0];
        s_d.rdata = 32'h0000_0000;
        if (addrPhase && !hwrite && (haddr[31:8] == 24'h00_0000)) begin
            unique case (haddr[7:0])
                `TCM_MODE_OFS: s_d.rdata = {16'h0000, s_d.mode};
                `TCM_CMP_OFS: s_d.rdata = {16'h0000, s_d.cmpWritten};
                `TCM_STAT_OFS: s_d.rdata = {s_d.cmpActive, 13'h0000, filtLevel, s_d.outRef};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            s_q <= '0;
            s_q.mode <= `TCM_MODE_RST;
            s_q.cmpWritten <= `TCM_CMP_RST;
            s_q.cmpActive <= `TCM_CMP_RST;
            s_q.readyOut <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign hreadyout = s_q.readyOut;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;
    assign ch1CaptureEvent = s_q.capEvent[0];
    assign ch2CaptureEvent = s_q.capEvent[1];
    assign ch2OutputReference = s_q.outRef;
    assign ch2FastResponseEn = s_q.fastEn;

    ////////////////////////////////////////////////////////////////////////////
    sequence preloadHeld;
        s_q.mode[`TCM_PEN2_BIT] && !updateEvent;
    endsequence

    chk_fast_layout: assert property (@(posedge ref_clk) disable iff (!rstN)
        sel[1] != 2'h0 |-> !ch2FastResponseEn)
        else $error("fast response shown in input layout");

    chk_sel1_locked: assert property (@(posedge ref_clk) disable iff (!rstN)
        wrMode && ch1EnableBit |=> s_q.mode[1:0] == $past(s_q.mode[1:0]))
        else $error("channel 1 selection changed while enabled");

    chk_sel2_locked: assert property (@(posedge ref_clk) disable iff (!rstN)
        wrMode && ch2EnableBit |=> s_q.mode[9:8] == $past(s_q.mode[9:8]))
        else $error("channel 2 selection changed while enabled");

    chk_ref_clear: assert property (@(posedge ref_clk) disable iff (!rstN)
        s_q.mode[15] && externalTriggerFiltered |=> !ch2OutputReference)
        else $error("reference not cleared by external input");

    chk_force_high: assert property (@(posedge ref_clk) disable iff (!rstN)
        sel[1] == 2'h0 && s_q.mode[14:12] == 3'h5 && !(s_q.mode[15] && externalTriggerFiltered)
        |=> ch2OutputReference)
        else $error("force high mode did not drive the reference high");

    chk_cmp_direct: assert property (@(posedge ref_clk) disable iff (!rstN)
        wrCmp && !s_q.mode[11] |=> s_q.cmpActive == $past(hwdata[15:0]))
        else $error("compare write without preload did not act at once");

    chk_cmp_preload: assert property (@(posedge ref_clk) disable iff (!rstN)
        preloadHeld |=> $stable(s_q.cmpActive))
        else $error("preloaded compare changed without an update event");

    chk_psc_count: assert property (@(posedge ref_clk) disable iff (!rstN)
        ch1CaptureEvent |-> $past(s_q.psCnt[0]) == $past(factorMinus1[0]) && $past(chActive[0]))
        else $error("channel 1 capture did not follow the prescale count");

    chk_input_noref: assert property (@(posedge ref_clk) disable iff (!rstN)
        sel[1] != 2'h0 |=> !ch2OutputReference && !$past(ch2CaptureEvent && !chActive[1]))
        else $error("reference driven in input layout");

    chk_bus_ready: assert property (@(posedge ref_clk) disable iff (!rstN)
        hreadyout && !hresp)
        else $error("slave inserted a wait state or error");

endmodule
`default_nettype wire

// ===== test/tcm_timer_model.sv
// Timer counter model: feeds the count and the update event to the mode block.
// Assumes the bench holds run low whenever it needs a frozen count and no update.
`timescale 1ns/1ns
`default_nettype none

module tcm_timer_model #(
    parameter int PERIOD = 32
) (
    input wire logic ref_clk, // timer clock
    input wire logic rstN, // reset, active low
    input wire logic run, // count enable
    output logic [15:0] counterValue, // current count
    output logic updateEvent // one-cycle pulse on wrap
);
    localparam logic [15:0] LAST = 16'(PERIOD - 1);

    // Update only on a real wrap, so a stopped counter never loads the preload
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            counterValue <= 16'h0000;
            updateEvent <= 1'h0;
        end else begin
            updateEvent <= run && (counterValue == LAST);
            if (run) begin
                counterValue <= (counterValue == LAST) ? 16'h0000 : counterValue + 16'h0001;
            end
        end
    end
endmodule

`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the channel 1/2 mode block.
// Assumes a zero-wait AHB-Lite slave and timer pins synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
`include "tcm_defs.svh"

module testbench;
    logic ref_clk = 1'h0, nrst = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic pinOne = 1'h0, pinTwo = 1'h0, trig = 1'h0, etr = 1'h0;
    logic en1 = 1'h0, en2 = 1'h0, run = 1'h0;
    logic upd, cap1, cap2, ref2, fast2;
    logic [15:0] cnt;
    logic [15:0] tbCmp = 16'h0;
    logic [2:0] tbMode = 3'h0;
    logic tbCen = 1'h0, refExp = 1'h0;
    int n_fail = 0, compares = 0, nCap1 = 0, nCap2 = 0;

    tcm_ch12_mode u_tcm_ch12_mode (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .inputPinOne(pinOne), .inputPinTwo(pinTwo),
        .internalTriggerSource(trig), .externalTriggerFiltered(etr), .ch1EnableBit(en1),
        .ch2EnableBit(en2), .counterValue(cnt), .updateEvent(upd), .ch1CaptureEvent(cap1),
        .ch2CaptureEvent(cap2), .ch2OutputReference(ref2), .ch2FastResponseEn(fast2));
    tcm_timer_model u_tcm_timer_model (.ref_clk(ref_clk), .rstN(nrst), .run(run), .counterValue(cnt),
        .updateEvent(upd));

    initial forever #2 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (cap1 === 1'h1) nCap1++;
        if (cap2 === 1'h1) nCap2++;
    end

    // Reference of the output level, one cycle behind its cause like the block
    always @(posedge ref_clk) begin
        case (tbMode)
            3'h1: if (cnt == tbCmp) refExp <= 1'h1;
            3'h2: if (cnt == tbCmp) refExp <= 1'h0;
            3'h3: if (cnt == tbCmp) refExp <= !refExp;
            3'h4: refExp <= 1'h0;
            3'h5: refExp <= 1'h1;
            3'h6: refExp <= cnt < tbCmp;
            3'h7: refExp <= cnt > tbCmp;
            default: ;
        endcase
        if (tbCen && etr) refExp <= 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Only the watchdog ends a wait for ready
    task automatic waitRdy();
        @(posedge ref_clk);
        while (hready !== 1'h1) @(posedge ref_clk);
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        waitRdy();
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        rdv = hrdata;
    endtask

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        ahb(1'h0, a, 32'h0);
        check(what, exp & m, rdv & m);
        check("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic setMode(input logic [31:0] d);
        ahb(1'h1, `TCM_MODE_OFS, d);
    endtask

    // A selection changes only while its own channel is off
    task automatic arm(input logic e);
        en1 <= e;
        en2 <= e;
        nCap1 = 0;
        nCap2 = 0;
    endtask

    task automatic pulse(input logic one, input logic two, input int len, input int gap);
        pinOne <= one;
        pinTwo <= two;
        ticks(len);
        pinOne <= 1'h0;
        pinTwo <= 1'h0;
        ticks(gap);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd("mode reset", `TCM_MODE_OFS, 32'h0, 32'hffff);
        rd("cmp reset", `TCM_CMP_OFS, 32'h0, 32'hffff);
        ahb(1'h1, 8'h0c, 32'hffff);
        rd("unmapped", 8'h0c, 32'h0, 32'hffffffff);
        setMode(32'h7ef5);
        rd("mode rw", `TCM_MODE_OFS, 32'h7ef5, 32'hffff);
        setMode(32'h0400);
        ticks(2);
        #1 check("fast out", 32'h1, {31'h0, fast2});
        setMode(32'h0500);
        ticks(2);
        #1 check("fast in", 32'h0, {31'h0, fast2});
        setMode(32'h0);
        arm(1'h1);
        setMode(32'h03f3);
        rd("sel locked", `TCM_MODE_OFS, 32'h00f0, 32'hffff);
        arm(1'h0);
        setMode(32'h03f3);
        rd("sel open", `TCM_MODE_OFS, 32'h03f3, 32'hffff);
        $display("regs done");
    endtask

    task automatic t_psc();
        int c;
        for (c = 0; c < 4; c++) begin
            setMode(32'h0303 | (c << 10) | (c << 2));
            arm(1'h1);
            repeat (8) begin
                trig <= 1'h1;
                ticks(4);
                trig <= 1'h0;
                ticks(4);
            end
            ticks(6);
            check("psc ch1", 32'(8 >> c), 32'(nCap1));
            check("psc ch2", 32'(8 >> c), 32'(nCap2));
            arm(1'h0);
        end
        $display("prescale done");
    endtask

    task automatic t_map();
        int m;
        for (m = 1; m < 3; m++) begin
            setMode(32'h0101 * m);
            arm(1'h1);
            repeat (3) pulse(1'h1, 1'h0, 1, 3);
            repeat (2) pulse(1'h0, 1'h1, 1, 3);
            ticks(4);
            check("map ch1", (m == 1) ? 32'h3 : 32'h2, 32'(nCap1));
            check("map ch2", (m == 1) ? 32'h2 : 32'h3, 32'(nCap2));
            arm(1'h0);
        end
        $display("mapping done");
    endtask

    task automatic t_filt();
        int codes[6] = '{1, 3, 5, 6, 10, 15};
        int divs[6] = '{1, 1, 2, 4, 16, 32};
        int ns[6] = '{2, 8, 8, 6, 5, 8};
        int i, d, n;
        for (i = 0; i < 6; i++) begin
            d = divs[i];
            n = ns[i];
            setMode(32'h0101 | (codes[i] << 12) | (codes[i] << 4));
            arm(1'h1);
            // Short pulse spans one sample fewer than the required run
            pulse(1'h1, 1'h1, d * (n - 1) - ((d > 1) ? 1 : 0), d * (n + 2));
            check("short ch1", 32'h0, 32'(nCap1));
            check("short ch2", 32'h0, 32'(nCap2));
            pulse(1'h1, 1'h1, d * (n + 2), d * (n + 2) + 4);
            check("long ch1", 32'h1, 32'(nCap1));
            check("long ch2", 32'h1, 32'(nCap2));
            arm(1'h0);
        end
        $display("filter done");
    endtask

    task automatic t_ref();
        logic [2:0] seq[9] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h5, 3'h4, 3'h6, 3'h7, 3'h5};
        int m, i, bad;
        setMode(32'h0);
        ahb(1'h1, `TCM_CMP_OFS, 32'h0010);
        rd("cmp direct", `TCM_STAT_OFS, 32'h00100000, 32'hffff0000);
        setMode(32'h0800);
        ahb(1'h1, `TCM_CMP_OFS, 32'h0005);
        rd("cmp held", `TCM_STAT_OFS, 32'h00100000, 32'hffff0000);
        run <= 1'h1;
        for (i = 0; i < 100 && upd !== 1'h1; i++) ticks(1);
        ticks(1);
        rd("cmp loaded", `TCM_STAT_OFS, 32'h00050000, 32'hffff0000);
        tbCmp <= 16'h0005;
        for (m = 0; m < 9; m++) begin
            setMode({16'h0, (m == 8), seq[m], 12'h0});
            tbMode <= seq[m];
            tbCen <= (m == 8);
            bad = 0;
            for (i = 0; i < 80; i++) begin
                @(posedge ref_clk);
                etr <= (i >= 20 && i < 40);
                #1 bad += (ref2 !== refExp);
            end
            check("ref level", 32'h0, 32'(bad));
        end
        rd("stat ref", `TCM_STAT_OFS, 32'h00050001, 32'hffff0007);
        $display("output done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1'h1;
        ticks(4);
        t_regs();
        t_psc();
        t_map();
        t_filt();
        t_ref();
        conclude();
    end

    initial begin
        #200000;
        n_fail++;
        $display("MISMATCH watchdog expected finish seen timeout");
        conclude();
    end
endmodule

`default_nettype wire
